/* emst_map.svh */
`ifndef EMST_MAP_SVH
`define EMST_MAP_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define EMST_ADDR_CSE 32'hf802_c068
`define EMST_ADDR_RRE 32'hf802_c06c
`define EMST_ADDR_ROV 32'hf802_c070
`define EMST_ADDR_RSE 32'hf802_c074
`define EMST_ADDR_ELE 32'hf802_c078
`define EMST_ADDR_RJA 32'hf802_c07c
`define EMST_ADDR_USF 32'hf802_c080
`define EMST_ADDR_STE 32'hf802_c084
`define EMST_ADDR_RLE 32'hf802_c088
`define EMST_ADDR_CFG 32'hf802_c0a0
`define EMST_ADDR_ISR 32'hf802_c0a4
`define EMST_ADDR_IMR 32'hf802_c0a8
`define EMST_ADDR_STEP 32'h0000_0004

// ----------------------------------------
// Counter indices, also status bit positions
// ----------------------------------------
`define EMST_NCNT 9
`define EMST_I_CSE 0
`define EMST_I_RRE 1
`define EMST_I_ROV 2
`define EMST_I_RSE 3
`define EMST_I_ELE 4
`define EMST_I_RJA 5
`define EMST_I_USF 6
`define EMST_I_STE 7
`define EMST_I_RLE 8

// ----------------------------------------
// Field masks and reset values
// ----------------------------------------
`define EMST_MASK8 16'h00ff
`define EMST_MASK16 16'hffff
`define EMST_CNT_RST 16'h0000
`define EMST_CFG_RST 32'h0000_0000
`define EMST_CFG_MASK 32'h0001_0102
`define EMST_CFG_FD_BIT 1
`define EMST_CFG_LONG_BIT 8
`define EMST_CFG_LCHK_BIT 16
`define EMST_EVT_RST 9'h000

// ----------------------------------------
// Frame length limits in bytes
// ----------------------------------------
`define EMST_MIN_LEN 16'h0040
`define EMST_MAX_LEN 16'h05ee
`define EMST_MAX_LONG 16'h0600
`define EMST_TYPE_ID 16'h0600
`define EMST_HDR_FCS 16'h0012

// ----------------------------------------
// Timing
// ----------------------------------------
`define EMST_SQE_BITS 96
`define EMST_BIT_NS 100
`define EMST_CLK_NS 50

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define EMST_RESP_OKAY 2'h0
`define EMST_RESP_SLVERR 2'h2

`endif

/* emst_phy_model.sv */
// ----------------------------------------
// Line side: one burst of tx_en, optional col
// ----------------------------------------
module emst_phy_model (
    // Clock
    input logic aclk,
    // Control
    input logic go,
    input logic give_col,
    // Line state
    output emst_pkg::emst_mii_s mii = '0
);
    timeunit 1ns;
    timeprecision 1ns;
    int n = 0;
    // Col lands 10 cycles after tx_en falls, well inside the gap
    always @(posedge aclk) begin
        if (go) begin
            n <= 1;
        end else if (n != 0 && n < 40) begin
            n <= n + 1;
        end else begin
            n <= 0;
        end
        mii.tx_en <= go || (n != 0 && n < 8);
        mii.col <= give_col && n >= 18 && n < 20;
    end
endmodule

/* emst_pkg.sv */
package emst_pkg;

    // ----------------------------------------
    // Event carriers
    // ----------------------------------------
    typedef struct packed {
        logic valid;
        logic collision;
        logic underrun;
        logic carrier_fault;
    } emst_tx_evt_s;

    typedef struct packed {
        logic valid;
        logic addr_match;
        logic no_buffer;
        logic overrun;
        logic symbol_err;
        logic crc_err;
        logic align_err;
        logic [15:0] length;
        logic [15:0] len_type;
    } emst_rx_evt_s;

    typedef struct packed {
        logic tx_en;
        logic col;
    } emst_mii_s;

    typedef logic [15:0] emst_cnt_t;

    typedef enum {
        SQE_IDLE,
        SQE_WAIT
    } emst_sqe_e;

endpackage

/* emst_stats.sv */
// The AXI4-Lite slave port was decided locally.
`include "emst_map.svh"

module emst_stats (
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // AXI4-Lite write channels
    input logic [31:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    // AXI4-Lite read channels
    input logic [31:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    // MAC event strobes
    input emst_pkg::emst_tx_evt_s tx_evt,
    input emst_pkg::emst_rx_evt_s rx_evt,
    // Line state
    input emst_pkg::emst_mii_s mii,
    // Interrupt
    output logic irq
);

    // ----------------------------------------
    // Constants and helpers
    // ----------------------------------------
    // Window taken at 10 Mbit/s bit time, rounded down
    localparam int sqe_cycles = (`EMST_SQE_BITS * `EMST_BIT_NS) / `EMST_CLK_NS;

    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = data[8*b +: 8];
            end
        end
        return res;
    endfunction

    function automatic emst_pkg::emst_cnt_t cnt_mask(input int idx);
        return (idx == `EMST_I_RRE) ? `EMST_MASK16 : `EMST_MASK8;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    emst_pkg::emst_cnt_t cnt [`EMST_NCNT];
    logic [31:0] cfg;
    logic [`EMST_NCNT-1:0] isr;
    logic [`EMST_NCNT-1:0] imr;
    logic [`EMST_NCNT-1:0] inc;
    logic aw_hold;
    logic w_hold;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_do;
    logic wr_ok;
    logic wr_cfg;
    logic wr_isr;
    logic wr_imr;
    logic [`EMST_NCNT-1:0] wr_sel;
    logic [31:0] wr_lanes;
    logic [31:0] rd_data;
    logic rd_ok;
    logic full_duplex;
    logic long_frames;
    logic len_check;
    logic tx_en_d;
    logic sqe_fire;
    logic [7:0] sqe_cnt;
    emst_pkg::emst_sqe_e sqe_state;
    logic [15:0] max_len;
    logic rx_bad;
    logic rx_over;
    logic rx_under;
    logic [31:0] imr_merged;

    assign full_duplex = cfg[`EMST_CFG_FD_BIT];
    assign long_frames = cfg[`EMST_CFG_LONG_BIT];
    assign len_check = cfg[`EMST_CFG_LCHK_BIT];
    assign wr_do = aw_hold & w_hold & ~s_axi_bvalid;
    assign wr_lanes = lane_merge(32'h0000_0000, w_data, w_strb);
    assign imr_merged = lane_merge({23'h00_0000, imr}, w_data, w_strb);

    // ----------------------------------------
    // Frame classification
    // ----------------------------------------
    assign max_len = long_frames ? `EMST_MAX_LONG : `EMST_MAX_LEN;
    assign rx_bad = rx_evt.crc_err | rx_evt.align_err | rx_evt.symbol_err;
    assign rx_over = rx_evt.length > max_len;
    assign rx_under = rx_evt.length < `EMST_MIN_LEN;

    always_comb begin
        inc = '0;
        // Underrun or collision frames never reach the carrier counter
        inc[`EMST_I_CSE] = tx_evt.valid & ~tx_evt.collision & ~tx_evt.underrun
                         & tx_evt.carrier_fault & ~full_duplex;
        inc[`EMST_I_RRE] = rx_evt.valid & rx_evt.addr_match & rx_evt.no_buffer;
        inc[`EMST_I_ROV] = rx_evt.valid & rx_evt.addr_match & rx_evt.overrun;
        inc[`EMST_I_RSE] = rx_evt.valid & rx_evt.symbol_err;
        inc[`EMST_I_ELE] = rx_evt.valid & rx_over & ~rx_bad;
        inc[`EMST_I_RJA] = rx_evt.valid & rx_over & rx_bad;
        inc[`EMST_I_USF] = rx_evt.valid & rx_under & ~rx_bad;
        inc[`EMST_I_STE] = sqe_fire;
        inc[`EMST_I_RLE] = rx_evt.valid & len_check & ~rx_over
                         & (rx_evt.len_type < `EMST_TYPE_ID)
                         & (rx_evt.length >= `EMST_HDR_FCS)
                         & ((rx_evt.length - `EMST_HDR_FCS) < rx_evt.len_type);
    end

    // ----------------------------------------
    // Quality test window after transmit
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_en_d <= 1'b0;
        end else begin
            tx_en_d <= mii.tx_en;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sqe_state <= emst_pkg::SQE_IDLE;
            sqe_cnt <= 8'h00;
            sqe_fire <= 1'b0;
        end else begin
            sqe_fire <= 1'b0;
            case (sqe_state)
                emst_pkg::SQE_IDLE: begin
                    if (tx_en_d && !mii.tx_en && !full_duplex) begin
                        sqe_state <= emst_pkg::SQE_WAIT;
                        sqe_cnt <= 8'h00;
                    end
                end
                emst_pkg::SQE_WAIT: begin
                    // An underrun frame must leave the counter alone
                    if (mii.col || mii.tx_en || (tx_evt.valid && tx_evt.underrun)) begin
                        sqe_state <= emst_pkg::SQE_IDLE;
                    end else if (sqe_cnt == 8'(sqe_cycles - 1)) begin
                        sqe_fire <= 1'b1;
                        sqe_state <= emst_pkg::SQE_IDLE;
                    end else begin
                        sqe_cnt <= sqe_cnt + 8'h01;
                    end
                end
                default: begin
                    sqe_state <= emst_pkg::SQE_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    always_comb begin
        wr_sel = '0;
        wr_cfg = 1'b0;
        wr_isr = 1'b0;
        wr_imr = 1'b0;
        wr_ok = 1'b1;
        if (aw_addr == `EMST_ADDR_CFG) begin
            wr_cfg = 1'b1;
        end else if (aw_addr == `EMST_ADDR_ISR) begin
            wr_isr = 1'b1;
        end else if (aw_addr == `EMST_ADDR_IMR) begin
            wr_imr = 1'b1;
        end else begin
            wr_ok = 1'b0;
            for (int i = 0; i < `EMST_NCNT; i++) begin
                if (aw_addr == `EMST_ADDR_CSE + `EMST_ADDR_STEP * 32'(i)) begin
                    wr_sel[i] = 1'b1;
                    wr_ok = 1'b1;
                end
            end
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b1;
        if (s_axi_araddr == `EMST_ADDR_CFG) begin
            rd_data = cfg;
        end else if (s_axi_araddr == `EMST_ADDR_ISR) begin
            rd_data = {23'h00_0000, isr};
        end else if (s_axi_araddr == `EMST_ADDR_IMR) begin
            rd_data = {23'h00_0000, imr};
        end else begin
            rd_ok = 1'b0;
            for (int i = 0; i < `EMST_NCNT; i++) begin
                if (s_axi_araddr == `EMST_ADDR_CSE + `EMST_ADDR_STEP * 32'(i)) begin
                    rd_data = {16'h0000, cnt[i]};
                    rd_ok = 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------
    // One write in flight; address and data accepted in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 32'h0000_0000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `EMST_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_do) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `EMST_RESP_OKAY : `EMST_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `EMST_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rd_ok ? `EMST_RESP_OKAY : `EMST_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Configuration, status and mask
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg <= `EMST_CFG_RST;
        end else if (wr_do && wr_cfg) begin
            cfg <= lane_merge(cfg, w_data, w_strb) & `EMST_CFG_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            imr <= `EMST_EVT_RST;
        end else if (wr_do && wr_imr) begin
            imr <= imr_merged[`EMST_NCNT-1:0];
        end
    end

    // New events win over a same-cycle clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            isr <= `EMST_EVT_RST;
        end else if (wr_do && wr_isr) begin
            isr <= (isr & ~wr_lanes[`EMST_NCNT-1:0]) | inc;
        end else begin
            isr <= isr | inc;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(isr & imr);
        end
    end

    // ----------------------------------------
    // Counters
    // ----------------------------------------
    // A write in the cycle of an event loads the written value plus one
    for (genvar gi = 0; gi < `EMST_NCNT; gi++) begin : g_cnt
        logic [31:0] merged;
        assign merged = lane_merge({16'h0000, cnt[gi]}, w_data, w_strb);
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cnt[gi] <= `EMST_CNT_RST;
            end else if (wr_do && wr_sel[gi]) begin
                cnt[gi] <= (merged[15:0] + {15'h0000, inc[gi]}) & cnt_mask(gi);
            end else if (inc[gi]) begin
                cnt[gi] <= (cnt[gi] + 16'h0001) & cnt_mask(gi);
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [127:0] other_cnt;
    assign other_cnt = {cnt[8], cnt[7], cnt[6], cnt[5], cnt[4], cnt[3], cnt[2], cnt[1]};

    chk_carrier_count: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_evt.valid && tx_evt.carrier_fault && !tx_evt.collision && !tx_evt.underrun && !full_duplex
        && !(wr_do && wr_sel[0]) |=> cnt[0] == (($past(cnt[0]) + 16'h0001) & `EMST_MASK8))
        else $error("carrier error count did not advance");
    chk_carrier_fd: assert property (@(posedge aclk) disable iff (!aresetn)
        full_duplex && !(wr_do && wr_sel[0]) |=> $stable(cnt[0]))
        else $error("carrier error counted in full duplex");
    chk_carrier_only: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_evt.valid && !rx_evt.valid && !sqe_fire && !wr_do |=> $stable(other_cnt))
        else $error("transmit event moved another counter");
    chk_resource_count: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_evt.valid && rx_evt.addr_match && rx_evt.no_buffer && !(wr_do && wr_sel[1])
        |=> cnt[1] == $past(cnt[1]) + 16'h0001)
        else $error("resource error count did not advance");
    chk_overrun_count: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_evt.valid && rx_evt.addr_match && rx_evt.overrun && !(wr_do && wr_sel[2])
        |=> cnt[2] == (($past(cnt[2]) + 16'h0001) & `EMST_MASK8))
        else $error("overrun count did not advance");
    chk_symbol_count: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_evt.valid && rx_evt.symbol_err && !(wr_do && wr_sel[3])
        |=> cnt[3] == (($past(cnt[3]) + 16'h0001) & `EMST_MASK8))
        else $error("symbol error count did not advance");
    chk_symbol_jabber: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_evt.valid && rx_evt.symbol_err && rx_evt.length > max_len |-> inc[5] && !inc[4])
        else $error("long symbol error frame not a jabber");
    chk_excess_len: assert property (@(posedge aclk) disable iff (!aresetn)
        inc[4] |-> rx_evt.length > max_len && !rx_evt.crc_err && !rx_evt.align_err && !rx_evt.symbol_err)
        else $error("excessive length counted wrongly");
    chk_jabber_len: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_evt.valid && rx_evt.crc_err && rx_evt.length > max_len && !(wr_do && wr_sel[5])
        |=> cnt[5] == (($past(cnt[5]) + 16'h0001) & `EMST_MASK8))
        else $error("jabber count did not advance");
    chk_undersize_len: assert property (@(posedge aclk) disable iff (!aresetn)
        inc[6] |-> rx_evt.length < `EMST_MIN_LEN && !rx_evt.crc_err && !rx_evt.align_err && !rx_evt.symbol_err)
        else $error("undersize counted wrongly");
    chk_sqe_window: assert property (@(posedge aclk) disable iff (!aresetn)
        sqe_fire |-> $past(mii.tx_en, 194) && !$past(mii.tx_en, 193) && !$past(mii.col))
        else $error("quality test error outside its window");
    chk_mismatch_len: assert property (@(posedge aclk) disable iff (!aresetn)
        inc[8] |-> rx_evt.length - `EMST_HDR_FCS < rx_evt.len_type)
        else $error("length mismatch on a long enough frame");
    chk_lencheck_off: assert property (@(posedge aclk) disable iff (!aresetn)
        !len_check && !(wr_do && wr_sel[8]) |=> $stable(cnt[8]))
        else $error("length checked while disabled");
    chk_type_id: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_evt.valid && (rx_evt.len_type >= `EMST_TYPE_ID || rx_over) |-> !inc[8])
        else $error("type field or long frame counted as mismatch");
    chk_long_limit: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_evt.valid && long_frames && rx_evt.length == `EMST_MAX_LONG |-> !inc[4] && !inc[5])
        else $error("1536 byte frame rejected with long frames on");
    chk_underrun_only: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_evt.valid && tx_evt.underrun && !rx_evt.valid && !sqe_fire && !wr_do
        |=> $stable(cnt[0]) && $stable(other_cnt))
        else $error("underrun frame moved a counter");
    chk_write_load: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_do && wr_sel[0] && !inc[0] && w_strb == 4'hf |=> cnt[0] == {8'h00, $past(w_data[7:0])})
        else $error("counter write did not load");

endmodule

/* tb_ethernet_mac_error_statistics.sv */
`include "emst_map.svh"
module tb_ethernet_mac_error_statistics;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 0, aresetn = 0, go = 0, give_col = 0, irq;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    emst_pkg::emst_tx_evt_s tx_evt = '0;
    emst_pkg::emst_rx_evt_s rx_evt = '0;
    emst_pkg::emst_mii_s mii;
    logic [31:0] exp [9];
    int errors = 0, checks = 0;
    emst_stats dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_evt(tx_evt),
        .rx_evt(rx_evt), .mii(mii), .irq(irq));
    emst_phy_model phy (.aclk(aclk), .go(go), .give_col(give_col), .mii(mii));
    initial begin
        forever #25 aclk = ~aclk;
    end
    // ----------------------------------------
    // Bus and event tasks
    // ----------------------------------------
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        forever begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) break;
        end
        bready <= 0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask
    task rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        forever begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
            if (rvalid) break;
        end
        rready <= 0;
        chk("rdata", e, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask
    task bump(input logic [8:0] m);
        for (int i = 0; i < 9; i++) if (m[i]) exp[i] = exp[i] + 1;
    endtask
    task tx(input logic [2:0] f, input logic [8:0] m);
        @(posedge aclk) tx_evt <= {1'b1, f};
        @(posedge aclk) tx_evt <= '0;
        bump(m);
    endtask
    task rx(input logic [5:0] f, input logic [15:0] len, input logic [15:0] lt, input logic [8:0] m);
        @(posedge aclk) rx_evt <= {1'b1, f, len, lt};
        @(posedge aclk) rx_evt <= '0;
        bump(m);
    endtask
    task sqe(input logic c, input logic [8:0] m);
        @(posedge aclk) begin go <= 1; give_col <= c; end
        @(posedge aclk) go <= 0;
        repeat (260) @(posedge aclk);
        bump(m);
    endtask
    task ck_all;
        for (int i = 0; i < 9; i++) rd(`EMST_ADDR_CSE + 32'(4 * i), exp[i], 2'h0);
    endtask
    task irq_is(input logic e);
        repeat (2) @(posedge aclk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask
    task end_of_test;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        #(50 * 20000);
        errors++;
        end_of_test();
    end
    initial begin
        foreach (exp[i]) exp[i] = 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        ck_all();
        tx(3'b001, 9'h001);
        tx(3'b101, 9'h000);
        tx(3'b011, 9'h000);
        rx(6'b110000, 100, 46, 9'h002);
        rx(6'b010000, 100, 46, 9'h000);
        rx(6'b101000, 100, 46, 9'h004);
        rx(6'b000100, 2000, 46, 9'h028);
        rx(6'b000100, 1518, 46, 9'h008);
        rx(6'b000000, 1519, 46, 9'h010);
        rx(6'b000000, 1518, 46, 9'h000);
        rx(6'b000010, 1600, 46, 9'h020);
        rx(6'b000001, 1600, 46, 9'h020);
        rx(6'b000000, 63, 46, 9'h040);
        rx(6'b000000, 64, 46, 9'h000);
        rx(6'b000010, 63, 46, 9'h000);
        ck_all();
        wr(`EMST_ADDR_CFG, 32'hffff_ffff);
        rd(`EMST_ADDR_CFG, `EMST_CFG_MASK, 2'h0);
        tx(3'b001, 9'h000);
        rx(6'b000000, 1536, 46, 9'h000);
        rx(6'b000000, 1537, 46, 9'h010);
        rx(6'b000000, 64, 47, 9'h100);
        rx(6'b000000, 64, 46, 9'h000);
        rx(6'b000000, 64, 16'h0600, 9'h000);
        rx(6'b000000, 2000, 16'h05ff, 9'h010);
        sqe(1'b0, 9'h000);
        wr(`EMST_ADDR_CFG, 32'h0000_0100);
        rx(6'b000000, 64, 47, 9'h000);
        sqe(1'b0, 9'h080);
        sqe(1'b1, 9'h000);
        ck_all();
        wr(`EMST_ADDR_ROV, 32'h1234_56ff);
        wr(`EMST_ADDR_RRE, 32'h1234_56ff);
        exp[`EMST_I_ROV] = 32'h0000_00ff;
        exp[`EMST_I_RRE] = 32'h0000_56ff;
        wr(`EMST_ADDR_CSE, 32'h0000_a5c3);
        exp[`EMST_I_CSE] = 32'h0000_00c3;
        wr(32'hf802_c0b0, 32'hffff_ffff, `EMST_RESP_SLVERR);
        ck_all();
        rd(32'hf802_c0b0, 32'h0000_0000, `EMST_RESP_SLVERR);
        rd(`EMST_ADDR_ISR, 32'h0000_01ff, 2'h0);
        irq_is(1'b0);
        wr(`EMST_ADDR_IMR, 32'h0000_0040);
        irq_is(1'b1);
        wr(`EMST_ADDR_ISR, 32'h0000_01bf);
        irq_is(1'b1);
        wr(`EMST_ADDR_ISR, 32'h0000_0040);
        irq_is(1'b0);
        wr(`EMST_ADDR_IMR, 32'h0000_0000);
        rd(`EMST_ADDR_IMR, 32'h0000_0000, 2'h0);
        end_of_test();
    end
endmodule
